// [fmd_map.svh]
// constants for the frame and multiframe delineator
`ifndef FMD_MAP_SVH
`define FMD_MAP_SVH
// frame geometry: positions of a 1584-bit frame, bit 0 first
`define FMD_POS_W        11
`define FMD_POS_LAST     11'h62F
`define FMD_POS_OH_FIRST 11'h61C
`define FMD_POS_OH_LAST  11'h62C
`define FMD_OH_BITS      17
// parity code: (x^13+1)(x^7+x+1) = x^20+x^14+x^13+x^7+x+1
`define FMD_FIRE_W       20
`define FMD_FIRE_POLY    20'h06083
`define FMD_FIRE_INIT    20'h00000
// descrambler x^17+x^14+1, history taps (index 0 newest)
`define FMD_SCR_W        17
`define FMD_SCR_TAP_A    16
`define FMD_SCR_TAP_B    2
// state code and multiframe markers
`define FMD_SC_W         3
`define FMD_MARK_A       3'h3
`define FMD_MARK_B       3'h1
`endif

// [fmd_pkg.sv]
// types and shared functions of the frame and multiframe delineator
`include "fmd_map.svh"
package fmd_pkg;

  typedef enum logic [1:0]
  {
    FMD_HUNT_FIRST  = 2'b00,
    FMD_HUNT_SECOND = 2'b01,
    FMD_VERIFY      = 2'b10,
    FMD_IN_FRAME    = 2'b11
  } fmd_frame_state_t;

  typedef logic [`FMD_FIRE_W-1:0] fmd_fire_t;

  // one step of the parity remainder, msb first
  function automatic fmd_fire_t fmd_fire_step(input fmd_fire_t rem,
                                              input logic      din);
    logic fb;
    fb = din ^ rem[`FMD_FIRE_W-1];
    fmd_fire_step = {rem[`FMD_FIRE_W-2:0], 1'b0} ^
                    (fb ? `FMD_FIRE_POLY : `FMD_FIRE_INIT);
  endfunction : fmd_fire_step

  // true for either multiframe marker code
  function automatic logic fmd_is_marker(input logic [`FMD_SC_W-1:0] sc);
    fmd_is_marker = (sc == `FMD_MARK_A) || (sc == `FMD_MARK_B);
  endfunction : fmd_is_marker

endpackage : fmd_pkg

// [fmd_stream_if.sv]
// valid/ready stream between the delineator and its buffer
`timescale 1ns/1ns
`default_nettype none
interface fmd_stream_if #(parameter int WIDTH = 2);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fmd_stream_if
`default_nettype wire

// [fmd_skid_buf.sv]
// two-entry buffer that keeps every word through a receiver stall
`timescale 1ns/1ns
`default_nettype none
module fmd_skid_buf
  import fmd_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  // clock and reset
  input  wire logic   clk_sys_in,
  input  wire logic   reset_n_in,
  // filling side
  fmd_stream_if.snk   in_if,
  // draining side
  output var logic             out_valid_out,
  output var logic [WIDTH-1:0] out_data_out,
  input  wire logic            out_ready_in
);

  logic             skid_valid;
  logic [WIDTH-1:0] skid_data;
  logic             in_ready;
  logic             next_skid_valid;
  wire              push = in_if.valid && in_ready;
  wire              pop  = out_valid_out && out_ready_in;
  wire              head_free = !out_valid_out || pop;

  assign in_if.ready = in_ready;

  // skid entry fills when the head is held and empties into the head
  assign next_skid_valid = head_free ? 1'b0 : (skid_valid || push);

  // head and skid registers
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
      skid_valid    <= 1'b0;
      skid_data     <= '0;
      in_ready      <= 1'b1;
    end
    else
    begin
      if (head_free)
      begin
        out_valid_out <= skid_valid || push;
        out_data_out  <= skid_valid ? skid_data : in_if.data;
      end
      else if (push)
        skid_data <= in_if.data;
      skid_valid <= next_skid_valid;
      in_ready   <= !next_skid_valid;
    end
  end

  // a stalled head word stays put
  property p_buf_hold;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (out_valid_out && !out_ready_in) |=>
      (out_valid_out && $stable(out_data_out));
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("buffered word changed while stalled");

  // a full buffer refuses the next word
  property p_buf_full;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (skid_valid && out_valid_out) |-> !in_if.ready;
  endproperty
  a_buf_full: assert property (p_buf_full)
    else $error("buffer ready while full");

endmodule : fmd_skid_buf
`default_nettype wire

// [fmd_mf_tracker.sv]
// multiframe alignment from the marker in the state code
`timescale 1ns/1ns
`default_nettype none
module fmd_mf_tracker
  import fmd_pkg::*;
#(
  parameter int LEN_W = 8,
  parameter int CNT_W = 4
)
(
  // clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                reset_n_in,
  // per-frame result from the framer
  input  wire logic                frame_tick_in,
  input  wire logic [`FMD_SC_W-1:0] state_code_in,
  input  wire logic                in_frame_in,
  // configuration
  input  wire logic                mf_enable_in,
  input  wire logic [LEN_W-1:0]    mf_length_in,
  input  wire logic [CNT_W-1:0]    loss_thr_in,
  input  wire logic [CNT_W-1:0]    lock_thr_in,
  // status
  output var logic                 in_multiframe_out
);

  logic [LEN_W-1:0] mf_pos;
  logic [CNT_W-1:0] good_cnt;
  logic [CNT_W-1:0] bad_cnt;
  logic             cand;
  logic             mf_bad;

  // sequence decode for the frame just ended
  wire marker   = fmd_is_marker(state_code_in);
  wire at_first = (mf_pos == '0);
  wire at_last  = (mf_pos == mf_length_in - LEN_W'(1));
  wire seq_ok   = (at_first == marker);
  wire [LEN_W-1:0] pos_step = at_last ? '0 : mf_pos + LEN_W'(1);
  wire [CNT_W-1:0] good_inc = good_cnt + CNT_W'(1);
  wire [CNT_W-1:0] bad_inc  = bad_cnt + CNT_W'(1);
  wire             hold_out = !mf_enable_in || !in_frame_in;

  // search, confirm and loss of multiframe alignment
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mf_pos            <= '0;
      good_cnt          <= '0;
      bad_cnt           <= '0;
      cand              <= 1'b0;
      mf_bad            <= 1'b0;
      in_multiframe_out <= 1'b0;
    end
    else if (hold_out)
    begin
      mf_pos            <= '0;
      good_cnt          <= '0;
      bad_cnt           <= '0;
      cand              <= 1'b0;
      mf_bad            <= 1'b0;
      in_multiframe_out <= 1'b0;
    end
    else if (frame_tick_in)
    begin
      if (in_multiframe_out)
      begin
        mf_pos <= pos_step;
        mf_bad <= at_last ? 1'b0 : (mf_bad || !seq_ok);
        if (at_last && (mf_bad || !seq_ok))
        begin
          bad_cnt <= bad_inc;
          if (bad_inc >= loss_thr_in)
          begin
            in_multiframe_out <= 1'b0;
            cand              <= 1'b0;
            good_cnt          <= '0;
          end
        end
        else if (at_last)
          bad_cnt <= '0;
      end
      else if (!cand || !seq_ok)
      begin
        // a marker opens a new candidate boundary
        cand     <= marker;
        mf_pos   <= marker ? LEN_W'(1) : '0;
        good_cnt <= '0;
      end
      else
      begin
        mf_pos <= pos_step;
        if (at_last)
        begin
          good_cnt <= good_inc;
          if (good_inc >= lock_thr_in)
          begin
            in_multiframe_out <= 1'b1;
            bad_cnt           <= '0;
            mf_bad            <= 1'b0;
          end
        end
      end
    end
  end

  // no multiframe lock while out of frame or disabled
  property p_mf_held;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    hold_out |=> !in_multiframe_out;
  endproperty
  a_mf_held: assert property (p_mf_held)
    else $error("multiframe lock while held out");

  // lock is only gained at the end of a multiframe
  property p_mf_gain;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(in_multiframe_out) |->
      $past(frame_tick_in && at_last && cand && seq_ok);
  endproperty
  a_mf_gain: assert property (p_mf_gain)
    else $error("multiframe lock gained off a boundary");

endmodule : fmd_mf_tracker
`default_nettype wire

// [fmd_delineator.sv]
// receive frame and multiframe delineation with descrambler sync
`timescale 1ns/1ns
`default_nettype none
// Operation
// - leave in-frame after loss-threshold bad frames
// - out of frame, hunt boundaries bit by bit
// - enter in-frame after lock-threshold good frames
// - may check only some parity bits
// - candidate count left to implementation
// - checksum over 1564 bits from candidate
// - descrambler state is checksum xor next 17
// - load descrambler, then free-run per bit
// - check second block's 17 descrambled bits
// - second-block mismatch slips to another bit
// - second-block match counts first good frame
// - leave multiframe after loss-threshold bad multiframes
// - hunt marker then N-1 unmarked frames
// - enter multiframe after lock-threshold good multiframes
// - multiframe length is a setting
// - marker codes 011 or 001 on first frame
// - no multiframe tracking when disabled
// - out of frame forces out of multiframe
// - descrambler x^17+x^14+1 advances every bit
// - parity code (x^13+1)(x^7+x+1) over scrambled bits
// - parity 19..3 at bits 1564..1580, 2..0 carry state
module fmd_delineator
  import fmd_pkg::*;
#(
  parameter int CNT_W      = 4,
  parameter int LEN_W      = 8,
  parameter int CHECK_BITS = `FMD_OH_BITS
)
(
  // clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_n_in,
  // received serial stream
  input  wire logic                 rx_bit_in,
  input  wire logic                 rx_valid_in,
  output var logic                  rx_ready_out,
  // configuration
  input  wire logic [CNT_W-1:0]     frame_loss_threshold_in,
  input  wire logic [CNT_W-1:0]     frame_lock_threshold_in,
  input  wire logic                 mf_enable_in,
  input  wire logic [LEN_W-1:0]     mf_length_in,
  input  wire logic [CNT_W-1:0]     multiframe_loss_threshold_in,
  input  wire logic [CNT_W-1:0]     multiframe_lock_threshold_in,
  // descrambled payload out
  output var logic                  data_valid_out,
  output var logic                  data_bit_out,
  output var logic                  data_sof_out,
  input  wire logic                 data_ready_in,
  // status
  output var logic                  in_frame_out,
  output var logic                  in_multiframe_out,
  output var logic [`FMD_SC_W-1:0]  state_code_out
);

  localparam logic [`FMD_POS_W-1:0] CHECK_LAST =
    `FMD_POS_OH_FIRST + `FMD_POS_W'(CHECK_BITS - 1);

  fmd_frame_state_t                state;
  fmd_frame_state_t                next_state;
  logic [`FMD_POS_W-1:0]           pos;
  logic [`FMD_POS_W-1:0]           next_pos;
  fmd_fire_t                       fire;
  logic [`FMD_SCR_W-1:0]           scr;
  logic [`FMD_SC_W-1:0]            sc_shift;
  logic                            frame_err;
  logic                            slip;
  logic [CNT_W-1:0]                good_cnt;
  logic [CNT_W-1:0]                bad_cnt;
  logic [CNT_W-1:0]                next_good_cnt;
  logic [CNT_W-1:0]                next_bad_cnt;
  logic                            next_slip;
  logic                            frame_tick;
  logic [`FMD_SC_W-1:0]            frame_sc;

  fmd_stream_if #(.WIDTH(2)) buf_if ();

  // bit acceptance is stalled by the output buffer
  wire adv       = rx_valid_in && buf_if.ready;
  wire at_last   = (pos == `FMD_POS_LAST);
  wire in_block  = (pos < `FMD_POS_OH_FIRST);
  wire in_oh     = !in_block && (pos <= `FMD_POS_OH_LAST);
  wire in_check  = !in_block && (pos <= CHECK_LAST);
  wire fec_bit   = fire[`FMD_FIRE_W-1];
  wire frame_end = adv && at_last && !slip;

  // descrambler keystream and descrambled bit
  wire ks_gen    = scr[`FMD_SCR_TAP_A] ^ scr[`FMD_SCR_TAP_B];
  wire loading   = (state == FMD_HUNT_FIRST) && in_oh;
  wire ks_cap    = rx_bit_in ^ fec_bit;
  wire ks_next   = loading ? ks_cap : ks_gen;
  wire dbit      = rx_bit_in ^ ks_gen;

  // per-bit parity comparison and end-of-frame verdict
  wire bit_bad   = (state != FMD_HUNT_FIRST) && in_check &&
                   (dbit != fec_bit);
  wire frame_ok  = !frame_err;
  wire [`FMD_SC_W-1:0] sc_now = {sc_shift[`FMD_SC_W-2:0], dbit ^ fec_bit};
  wire [CNT_W-1:0] good_inc = good_cnt + CNT_W'(1);
  wire [CNT_W-1:0] bad_inc  = bad_cnt + CNT_W'(1);

  // frame position, with a one-bit hold to move the candidate
  always_comb
  begin
    if (at_last && !slip)
      next_pos = next_slip ? pos : '0;
    else if (at_last)
      next_pos = '0;
    else
      next_pos = pos + `FMD_POS_W'(1);
  end

  // frame alignment state machine, evaluated once per frame
  always_comb
  begin
    next_state    = state;
    next_good_cnt = good_cnt;
    next_bad_cnt  = bad_cnt;
    next_slip     = 1'b0;
    if (at_last && !slip)
    begin
      unique case (state)
        FMD_HUNT_FIRST:
          next_state = FMD_HUNT_SECOND;
        FMD_HUNT_SECOND:
        begin
          next_good_cnt = CNT_W'(1);
          next_state    = !frame_ok ? FMD_HUNT_FIRST :
                          (frame_lock_threshold_in <= CNT_W'(1)) ?
                          FMD_IN_FRAME : FMD_VERIFY;
          next_slip     = !frame_ok;
        end
        FMD_VERIFY:
        begin
          next_good_cnt = good_inc;
          next_state    = !frame_ok ? FMD_HUNT_FIRST :
                          (good_inc >= frame_lock_threshold_in) ?
                          FMD_IN_FRAME : FMD_VERIFY;
          next_slip     = !frame_ok;
        end
        FMD_IN_FRAME:
        begin
          next_bad_cnt = frame_ok ? '0 : bad_inc;
          if (!frame_ok && (bad_inc >= frame_loss_threshold_in))
          begin
            next_state = FMD_HUNT_FIRST;
            next_slip  = 1'b1;
          end
        end
      endcase
      if (next_state != FMD_IN_FRAME)
        next_bad_cnt = '0;
    end
  end

  // position, state and counters
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pos      <= '0;
      state    <= FMD_HUNT_FIRST;
      good_cnt <= '0;
      bad_cnt  <= '0;
      slip     <= 1'b0;
    end
    else if (adv)
    begin
      pos      <= next_pos;
      state    <= next_state;
      good_cnt <= next_good_cnt;
      bad_cnt  <= next_bad_cnt;
      slip     <= next_slip;
    end
  end

  // parity remainder over the block, then shifted out
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      fire <= `FMD_FIRE_INIT;
    else if (adv && (pos == '0))
      fire <= fmd_fire_step(`FMD_FIRE_INIT, rx_bit_in);
    else if (adv && in_block)
      fire <= fmd_fire_step(fire, rx_bit_in);
    else if (adv)
      fire <= {fire[`FMD_FIRE_W-2:0], 1'b0};
  end

  // descrambler history, loaded from the overhead then free-running
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      scr <= '0;
    else if (adv)
      scr <= {scr[`FMD_SCR_W-2:0], ks_next};
  end

  // frame error flag and state code capture
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      frame_err <= 1'b0;
      sc_shift  <= '0;
    end
    else if (adv)
    begin
      frame_err <= (at_last || slip) ? 1'b0 : (frame_err || bit_bad);
      if (pos > `FMD_POS_OH_LAST)
        sc_shift <= sc_now;
    end
  end

  // per-frame result handed to the multiframe tracker
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      frame_tick     <= 1'b0;
      frame_sc       <= '0;
      state_code_out <= '0;
      in_frame_out   <= 1'b0;
    end
    else
    begin
      frame_tick <= frame_end && (state == FMD_IN_FRAME);
      if (frame_end)
      begin
        frame_sc       <= sc_now;
        state_code_out <= sc_now;
      end
      if (adv)
        in_frame_out <= (next_state == FMD_IN_FRAME);
    end
  end

  // payload bits go to the buffer only while in frame
  assign buf_if.valid = rx_valid_in && (state == FMD_IN_FRAME) &&
                        in_block && !slip;
  assign buf_if.data  = {pos == '0, dbit};
  assign rx_ready_out = buf_if.ready;

  // multiframe alignment
  fmd_mf_tracker #(
    .LEN_W (LEN_W),
    .CNT_W (CNT_W)
  ) u_mf (
    .clk_sys_in        (clk_sys_in),
    .reset_n_in        (reset_n_in),
    .frame_tick_in     (frame_tick),
    .state_code_in     (frame_sc),
    .in_frame_in       (in_frame_out),
    .mf_enable_in      (mf_enable_in),
    .mf_length_in      (mf_length_in),
    .loss_thr_in       (multiframe_loss_threshold_in),
    .lock_thr_in       (multiframe_lock_threshold_in),
    .in_multiframe_out (in_multiframe_out)
  );

  // payload buffer
  fmd_skid_buf #(
    .WIDTH (2)
  ) u_buf (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .in_if         (buf_if),
    .out_valid_out (data_valid_out),
    .out_data_out  ({data_sof_out, data_bit_out}),
    .out_ready_in  (data_ready_in)
  );

  // enough bad frames in frame drop the lock
  property p_loss;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (frame_end && (state == FMD_IN_FRAME) && !frame_ok &&
     (bad_inc >= frame_loss_threshold_in)) |=>
      ((state == FMD_HUNT_FIRST) && slip);
  endproperty
  a_loss: assert property (p_loss)
    else $error("frame lock kept past loss threshold");

  // a failed second block moves the candidate by one bit
  property p_slip;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (frame_end && (state == FMD_HUNT_SECOND) && !frame_ok) |=>
      ((pos == `FMD_POS_LAST) && slip && (state == FMD_HUNT_FIRST));
  endproperty
  a_slip: assert property (p_slip)
    else $error("second block failure did not slip");

  // lock entry only from a good frame with enough matches
  property p_lock;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    ($changed(state) && (state == FMD_IN_FRAME)) |->
      $past(frame_ok && ((state == FMD_HUNT_SECOND) ||
            (good_inc >= frame_lock_threshold_in)));
  endproperty
  a_lock: assert property (p_lock)
    else $error("in-frame entered without lock threshold");

  // status output follows the frame state
  property p_status;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    in_frame_out == (state == FMD_IN_FRAME);
  endproperty
  a_status: assert property (p_status)
    else $error("in-frame status disagrees with state");

  // no payload leaves the framer before lock
  property p_squelch;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    buf_if.valid |-> (in_frame_out && in_block);
  endproperty
  a_squelch: assert property (p_squelch)
    else $error("payload pushed while out of frame");

endmodule : fmd_delineator
`default_nettype wire

// [fmd_tx_model.sv]
// transmitter framer model that feeds scrambled frames to the delineator
`timescale 1ns/1ns
`default_nettype none
module fmd_tx_model
(
  // clock and controls
  input  wire logic        clk_sys_in,
  input  wire logic        run_in,
  input  wire logic        bad_in,
  input  wire logic [2:0]  sc_in,
  input  wire logic [31:0] pat_in,
  // serial stream
  output var  logic        bit_out,
  output var  logic        valid_out,
  input  wire logic        ready_in,
  // count of frames fully taken
  output var  int          frames_out
);
  logic [16:0] hist = 17'h1ACE1;
  logic [19:0] rem  = 20'h00000;
  int          pos  = 0;
  logic        plain;

  initial
  begin
    bit_out    = 1'b0;
    valid_out  = 1'b0;
    frames_out = 0;
  end

  // advance on every taken bit, then offer the next one after the edge
  always @(posedge clk_sys_in)
  begin
    if (valid_out && ready_in)
    begin
      hist = {hist[15:0], hist[16] ^ hist[2]};
      if (pos < 1564)
        rem = {rem[18:0], 1'b0} ^
              ((bit_out ^ rem[19]) ? 20'h06083 : 20'h00000);
      pos = (pos == 1583) ? 0 : pos + 1;
      if (pos == 0)
      begin
        rem        = 20'h00000;
        frames_out = frames_out + 1;
      end
    end
    #1;
    if (!run_in)
    begin
      pos       = 0;
      rem       = 20'h00000;
      valid_out = 1'b0;
      bit_out   = ~bit_out; // idle line keeps changing
    end
    else
    begin
      // parity tail with the state code folded into its low three bits
      if (pos < 1564)
        plain = pat_in[pos % 32];
      else
        plain = rem[1583 - pos] ^ (pos > 1580 && sc_in[1583 - pos]) ^
                (bad_in && pos == 1564);
      bit_out   = plain ^ hist[16] ^ hist[2];
      valid_out = 1'b1;
    end
  end
endmodule : fmd_tx_model
`default_nettype wire

// [fmd_delineator_tb.sv]
// self-checking bench for the frame and multiframe delineator
`timescale 1ns/1ns
`default_nettype none
module fmd_delineator_tb;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        run, bad, mf_en, data_ready, rx_bit, rx_valid, rx_ready;
  logic        d_valid, d_bit, d_sof, in_frame, in_mf;
  logic        osync = 1'b0;
  logic [2:0]  sc, sc_out;
  logic [31:0] pat;
  logic [3:0]  loss_thr, lock_thr, mloss, mlock;
  logic [7:0]  mf_len;
  int          frames, opos = 0, fails = 0, n_checks = 0;

  // 50 MHz system clock
  always #10 clk_sys_in = ~clk_sys_in;

  fmd_tx_model u_tx (.clk_sys_in(clk_sys_in), .run_in(run), .bad_in(bad),
    .sc_in(sc), .pat_in(pat), .bit_out(rx_bit), .valid_out(rx_valid),
    .ready_in(rx_ready), .frames_out(frames));

  fmd_delineator u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .rx_bit_in(rx_bit), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
    .frame_loss_threshold_in(loss_thr), .frame_lock_threshold_in(lock_thr),
    .mf_enable_in(mf_en), .mf_length_in(mf_len),
    .multiframe_loss_threshold_in(mloss),
    .multiframe_lock_threshold_in(mlock), .data_valid_out(d_valid),
    .data_bit_out(d_bit), .data_sof_out(d_sof), .data_ready_in(data_ready),
    .in_frame_out(in_frame), .in_multiframe_out(in_mf),
    .state_code_out(sc_out));

  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic rst;
    run        = 1'b0;
    reset_n_in = 1'b0;
    osync      = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    #1;
    reset_n_in = 1'b1;
    run        = 1'b1;
  endtask : rst

  // send n frames, markers on even frames when asked, then check the code
  task automatic frm(input int n, input bit mark);
    int lim;
    repeat (n)
    begin
      sc  = (mark && frames % 2 == 0) ? (frames[1] ? 3'h3 : 3'h1) : 3'h6;
      lim = frames + 1;
      for (int i = 0; i < 4000 && frames < lim; i++)
        @(posedge clk_sys_in);
      if (frames < lim)
      begin
        fails++;
        end_sim();
      end
      repeat (2) @(posedge clk_sys_in);
      #1;
      if (in_frame === 1'b1)
        chk(sc_out, sc);
    end
  endtask : frm

  // sink stalls about one cycle in eight
  always @(posedge clk_sys_in)
  begin
    #1;
    data_ready = ($urandom % 8) != 0;
  end

  // payload bits must repeat the sent pattern, frame start marked
  always @(posedge clk_sys_in)
    if (d_valid === 1'b1 && data_ready === 1'b1 && in_frame === 1'b1)
    begin
      if (osync)
        chk(d_sof, opos == 1563);
      opos  = d_sof ? 0 : opos + 1;
      osync = osync | d_sof;
      if (osync)
        chk(d_bit, pat[opos % 32]);
    end

  // main sequence
  initial
  begin
    pat = $urandom(32'h147B);
    {run, bad, mf_en, data_ready, sc} = 7'h00;
    {loss_thr, lock_thr, mloss, mlock} = 16'h2322;
    mf_len = 8'h02;
    rst();
    chk(rx_ready, 1'b1);
    chk({in_frame, in_mf, d_valid}, 3'h0);
    frm(3, 1'b1);
    chk(in_frame, 1'b0);
    frm(1, 1'b1);
    chk(in_frame, 1'b1);
    frm(4, 1'b1);
    chk(in_mf, 1'b0);
    bad = 1'b1;
    frm(1, 1'b1);
    chk(in_frame, 1'b1);
    bad = 1'b0;
    frm(1, 1'b1);
    bad = 1'b1;
    frm(1, 1'b1);
    chk(in_frame, 1'b1);
    frm(1, 1'b1);
    chk(in_frame, 1'b0);
    bad   = 1'b0;
    mf_en = 1'b1;
    rst();
    chk(in_frame, 1'b0);
    frm(5, 1'b1);
    chk(in_mf, 1'b0);
    frm(11, 1'b1);
    chk(in_mf, 1'b1);
    if (frames % 2)
      frm(1, 1'b1);
    frm(2, 1'b0);
    chk(in_mf, 1'b1);
    frm(2, 1'b0);
    chk(in_mf, 1'b0);
    frm(10, 1'b1);
    chk(in_mf, 1'b1);
    bad = 1'b1;
    frm(2, 1'b1);
    chk(in_frame, 1'b0);
    chk(in_mf, 1'b0);
    end_sim();
  end

  // watchdog against a hung run
  initial
  begin
    repeat (95000) @(posedge clk_sys_in);
    fails++;
    end_sim();
  end
endmodule : fmd_delineator_tb
`default_nettype wire
